/* File: shared/sac_pkg.sv */
package sac_pkg;

	localparam logic [7:0] ADDR_CTRL   = 8'h1f;
	localparam logic [7:0] ADDR_PINCFG = 8'h9f;
	localparam logic [7:0] ADDR_RESULT = 8'h1e;
	localparam logic [7:0] ADDR_FLAG   = 8'h0c;
	localparam logic [7:0] ADDR_IRQEN  = 8'h8c;
	localparam logic [7:0] ADDR_PORT   = 8'h06;

	localparam int CTRL_CLK_HI = 7;
	localparam int CTRL_CLK_LO = 6;
	localparam int CTRL_CH_HI  = 4;
	localparam int CTRL_CH_LO  = 3;
	localparam int CTRL_GO     = 2;
	localparam int CTRL_ON     = 0;
	localparam int PCFG_HI     = 2;
	localparam int FLAG_DONE   = 6;
	localparam int PORT_W      = 6;

	localparam logic [1:0] RST_CLK_SEL = 2'h0;
	localparam logic [1:0] RST_CHAN    = 2'h0;
	localparam logic [2:0] RST_PCFG    = 3'h0;
	localparam logic [7:0] RST_RESULT  = 8'h00;
	localparam logic [7:0] RST_RDATA   = 8'h00;
	localparam logic [2:0] PCFG_ALL_D  = 3'h7;

	localparam logic [1:0] CLK_SEL_DIV2  = 2'h0;
	localparam logic [1:0] CLK_SEL_DIV8  = 2'h1;
	localparam logic [1:0] CLK_SEL_DIV32 = 2'h2;
	localparam logic [1:0] CLK_SEL_RC    = 2'h3;

	localparam int MCLK_NS   = 40;
	localparam int RC_TAD_NS = 4000;
	localparam logic [5:0] DIV2_HALF  = 6'h01;
	localparam logic [5:0] DIV8_HALF  = 6'h04;
	localparam logic [5:0] DIV32_HALF = 6'h10;
	localparam logic [5:0] RC_HALF    = 6'(RC_TAD_NS / (2 * MCLK_NS));

	localparam logic [4:0] INSTR_CYC   = 5'h04;
	localparam logic [4:0] CONV_HALF   = 5'h13;
	localparam logic [4:0] HOLD_HALF   = 5'h04;
	localparam logic [4:0] LAST_DECIDE = 5'h0f;
	localparam logic [4:0] CNT_ZERO    = 5'h00;
	localparam logic [4:0] CNT_ONE     = 5'h01;
	localparam logic [7:0] SAR_MSB     = 8'h80;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_RCWAIT = 2'b01,
		ST_CONV   = 2'b10,
		ST_HOLD   = 2'b11
	} sac_state_t;

	function automatic logic [5:0] sac_analog_mask(input logic [2:0] cfg);
		case (cfg)
			3'h0, 3'h1: sac_analog_mask = 6'h17;
			3'h2, 3'h3: sac_analog_mask = 6'h07;
			3'h4, 3'h5: sac_analog_mask = 6'h03;
			3'h6:       sac_analog_mask = 6'h01;
			default:    sac_analog_mask = 6'h00;
		endcase
	endfunction : sac_analog_mask

	function automatic logic sac_ref_ext(input logic [2:0] cfg);
		sac_ref_ext = cfg[0] && (cfg != PCFG_ALL_D);
	endfunction : sac_ref_ext

endpackage : sac_pkg

/* File: src/sac_tad_gen.sv */
`timescale 1ns/1ps
module sac_tad_gen (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [1:0] clkSel,
	output logic            halfTick
);

	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic [5:0] halfLen;
	logic       next_halfTick;

	// Half a conversion clock period, counted in system clocks.
	always_comb begin
		case (clkSel)
			sac_pkg::CLK_SEL_DIV2:  halfLen = sac_pkg::DIV2_HALF;
			sac_pkg::CLK_SEL_DIV8:  halfLen = sac_pkg::DIV8_HALF;
			sac_pkg::CLK_SEL_DIV32: halfLen = sac_pkg::DIV32_HALF;
			default:                halfLen = sac_pkg::RC_HALF;
		endcase
		next_cnt      = cnt;
		next_halfTick = 1'b0;
		if (!run) begin
			next_cnt = 6'h00;
		end else if (cnt >= halfLen - 6'h01) begin
			next_cnt      = 6'h00;
			next_halfTick = 1'b1;
		end else begin
			next_cnt = cnt + 6'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt      <= 6'h00;
			halfTick <= 1'b0;
		end else begin
			cnt      <= next_cnt;
			halfTick <= next_halfTick;
		end
	end

endmodule : sac_tad_gen

/* File: src/sac_control.sv */
`timescale 1ns/1ps
// How it works
// - Eight-bit unsigned result by successive approximation.
// - Reference is supply or external pin.
// - Clock select: osc/2, osc/8, osc/32, RC.
// - Channel select field routes one of four inputs.
// - Writing go starts; reads one while busy.
// - Hardware clears go when conversion ends.
// - Done loads result, clears go, sets flag.
// - Converter off holds block idle and unpowered.
// - Three-bit pin field, upper bits zero, reset 000.
// - Pin field decodes analog pins and reference.
// - Port read returns zero on analog pins.
// - Pin field write may raise pin flags.
// - Holding cap disconnected two periods after conversion.
// - Holding cap never discharged between conversions.
// - Conversion continues during sleep on RC clock.
// - Conversion lasts nine and a half periods.
// - Clearing go aborts, result kept, then hold.
// - RC waits one cycle; sleep aborts otherwise.
// - Sleep completion wakes, or powers converter down.
module sac_control (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wrEn,
	input  wire logic       rdEn,
	input  wire logic       compHigh,
	input  wire logic [5:0] portPins,
	input  wire logic       cpuSleep,
	output logic      [7:0] rdata,
	output logic      [1:0] chanSel,
	output logic            refExternal,
	output logic      [5:0] analogPins,
	output logic            sampleOn,
	output logic            powered,
	output logic      [7:0] dacCode,
	output logic            wakeReq,
	output logic            pinCfgWrote
);

	logic [1:0] clkSel;
	logic       converterOn;
	logic [2:0] pinCfg;
	logic       doneIrqEn;
	logic [1:0] next_clkSel;
	logic [1:0] next_chanSel;
	logic       next_converterOn;
	logic [2:0] next_pinCfg;
	logic       next_doneIrqEn;
	logic       next_refExternal;
	logic [5:0] next_analogPins;
	logic       next_pinCfgWrote;

	sac_pkg::sac_state_t st;
	sac_pkg::sac_state_t next_st;
	logic [4:0] halfCnt;
	logic [4:0] next_halfCnt;
	logic [7:0] sar;
	logic [7:0] next_sar;
	logic [7:0] result;
	logic [7:0] next_result;
	logic       doneFlag;
	logic       next_doneFlag;
	logic       powerDown;
	logic       next_powerDown;
	logic       next_wakeReq;
	logic       next_powered;
	logic       next_sampleOn;
	logic       doneEv;
	logic [7:0] bitMask;
	logic [7:0] next_rdata;

	logic wrCtrl;
	logic wrPinCfg;
	logic goFlag;
	logic startReq;
	logic abortReq;
	logic sleepAbort;
	logic halfTick;

	assign wrCtrl   = wrEn && (addr == sac_pkg::ADDR_CTRL);
	assign wrPinCfg = wrEn && (addr == sac_pkg::ADDR_PINCFG);
	assign goFlag   = (st == sac_pkg::ST_RCWAIT) || (st == sac_pkg::ST_CONV);
	assign startReq = wrCtrl && wdata[sac_pkg::CTRL_GO] && converterOn && !powerDown
		&& (st == sac_pkg::ST_IDLE);
	assign abortReq = wrCtrl && !wdata[sac_pkg::CTRL_GO] && goFlag;
	assign sleepAbort = cpuSleep && (clkSel != sac_pkg::CLK_SEL_RC);

	sac_tad_gen i_sac_tad_gen (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.run      (powered && (st != sac_pkg::ST_IDLE) && !abortReq),
		.clkSel   (clkSel),
		.halfTick (halfTick)
	);

	// Configuration registers and the pin decode they drive.
	always_comb begin
		next_clkSel      = clkSel;
		next_chanSel     = chanSel;
		next_converterOn = converterOn;
		next_pinCfg      = pinCfg;
		next_doneIrqEn   = doneIrqEn;
		next_pinCfgWrote = wrPinCfg;
		if (wrCtrl) begin
			next_clkSel      = wdata[sac_pkg::CTRL_CLK_HI:sac_pkg::CTRL_CLK_LO];
			next_chanSel     = wdata[sac_pkg::CTRL_CH_HI:sac_pkg::CTRL_CH_LO];
			next_converterOn = wdata[sac_pkg::CTRL_ON];
		end
		if (wrPinCfg) begin
			next_pinCfg = wdata[sac_pkg::PCFG_HI:0];
		end
		if (wrEn && (addr == sac_pkg::ADDR_IRQEN)) begin
			next_doneIrqEn = wdata[sac_pkg::FLAG_DONE];
		end
		next_analogPins  = sac_pkg::sac_analog_mask(next_pinCfg);
		next_refExternal = sac_pkg::sac_ref_ext(next_pinCfg);
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			clkSel      <= sac_pkg::RST_CLK_SEL;
			chanSel     <= sac_pkg::RST_CHAN;
			converterOn <= 1'b0;
			pinCfg      <= sac_pkg::RST_PCFG;
			doneIrqEn   <= 1'b0;
			analogPins  <= sac_pkg::sac_analog_mask(sac_pkg::RST_PCFG);
			refExternal <= 1'b0;
			pinCfgWrote <= 1'b0;
		end else begin
			clkSel      <= next_clkSel;
			chanSel     <= next_chanSel;
			converterOn <= next_converterOn;
			pinCfg      <= next_pinCfg;
			doneIrqEn   <= next_doneIrqEn;
			analogPins  <= next_analogPins;
			refExternal <= next_refExternal;
			pinCfgWrote <= next_pinCfgWrote;
		end
	end

	// Conversion sequencer with its approximation register and flags.
	always_comb begin
		next_st        = st;
		next_halfCnt   = halfCnt;
		next_sar       = sar;
		next_result    = result;
		next_powerDown = powerDown;
		next_wakeReq   = 1'b0;
		doneEv         = 1'b0;
		bitMask        = sac_pkg::SAR_MSB >> halfCnt[3:1];
		if (wrEn && (addr == sac_pkg::ADDR_RESULT)) begin
			next_result = wdata;
		end
		if (!cpuSleep) begin
			next_powerDown = 1'b0;
		end
		if (!converterOn || powerDown) begin
			next_st      = sac_pkg::ST_IDLE;
			next_halfCnt = sac_pkg::CNT_ZERO;
		end else begin
			case (st)
				sac_pkg::ST_IDLE: begin
					if (startReq) begin
						next_halfCnt = sac_pkg::CNT_ZERO;
						next_sar     = sac_pkg::SAR_MSB;
						if (clkSel == sac_pkg::CLK_SEL_RC) begin
							next_st = sac_pkg::ST_RCWAIT;
						end else begin
							next_st = sac_pkg::ST_CONV;
						end
					end
				end
				sac_pkg::ST_RCWAIT: begin
					if (abortReq) begin
						next_st      = sac_pkg::ST_HOLD;
						next_halfCnt = sac_pkg::CNT_ZERO;
					end else if (halfCnt == sac_pkg::INSTR_CYC - sac_pkg::CNT_ONE) begin
						next_st      = sac_pkg::ST_CONV;
						next_halfCnt = sac_pkg::CNT_ZERO;
					end else begin
						next_halfCnt = halfCnt + sac_pkg::CNT_ONE;
					end
				end
				sac_pkg::ST_CONV: begin
					if (abortReq) begin
						next_st      = sac_pkg::ST_HOLD;
						next_halfCnt = sac_pkg::CNT_ZERO;
					end else if (sleepAbort) begin
						next_st        = sac_pkg::ST_IDLE;
						next_halfCnt   = sac_pkg::CNT_ZERO;
						next_powerDown = 1'b1;
					end else if (halfTick) begin
						if (halfCnt == sac_pkg::CONV_HALF - sac_pkg::CNT_ONE) begin
							doneEv       = 1'b1;
							next_result  = sar;
							next_st      = sac_pkg::ST_HOLD;
							next_halfCnt = sac_pkg::CNT_ZERO;
							if (cpuSleep && doneIrqEn) begin
								next_wakeReq = 1'b1;
							end else if (cpuSleep) begin
								next_powerDown = 1'b1;
							end
						end else begin
							next_halfCnt = halfCnt + sac_pkg::CNT_ONE;
						end
						if (halfCnt[0] && (halfCnt <= sac_pkg::LAST_DECIDE)) begin
							next_sar = (compHigh ? sar : (sar & ~bitMask)) | (bitMask >> 1);
						end
					end
				end
				sac_pkg::ST_HOLD: begin
					if (halfTick) begin
						if (halfCnt == sac_pkg::HOLD_HALF - sac_pkg::CNT_ONE) begin
							next_st      = sac_pkg::ST_IDLE;
							next_halfCnt = sac_pkg::CNT_ZERO;
						end else begin
							next_halfCnt = halfCnt + sac_pkg::CNT_ONE;
						end
					end
				end
				default: begin
					next_st      = sac_pkg::ST_IDLE;
					next_halfCnt = sac_pkg::CNT_ZERO;
				end
			endcase
		end
		next_doneFlag = doneFlag;
		if (wrEn && (addr == sac_pkg::ADDR_FLAG)) begin
			next_doneFlag = wdata[sac_pkg::FLAG_DONE];
		end
		if (doneEv) begin
			next_doneFlag = 1'b1;
		end
		next_powered  = next_converterOn && !next_powerDown;
		next_sampleOn = next_powered && (next_st == sac_pkg::ST_IDLE);
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st        <= sac_pkg::ST_IDLE;
			halfCnt   <= sac_pkg::CNT_ZERO;
			sar       <= sac_pkg::SAR_MSB;
			dacCode   <= sac_pkg::SAR_MSB;
			result    <= sac_pkg::RST_RESULT;
			doneFlag  <= 1'b0;
			powerDown <= 1'b0;
			wakeReq   <= 1'b0;
			powered   <= 1'b0;
			sampleOn  <= 1'b0;
		end else begin
			st        <= next_st;
			halfCnt   <= next_halfCnt;
			sar       <= next_sar;
			dacCode   <= next_sar;
			result    <= next_result;
			doneFlag  <= next_doneFlag;
			powerDown <= next_powerDown;
			wakeReq   <= next_wakeReq;
			powered   <= next_powered;
			sampleOn  <= next_sampleOn;
		end
	end

	// Register read port, data valid one cycle after the strobe.
	always_comb begin
		next_rdata = sac_pkg::RST_RDATA;
		if (rdEn) begin
			case (addr)
				sac_pkg::ADDR_CTRL:   next_rdata = {clkSel, 1'b0, chanSel, goFlag, 1'b0,
					converterOn};
				sac_pkg::ADDR_PINCFG: next_rdata = {5'h00, pinCfg};
				sac_pkg::ADDR_RESULT: next_rdata = result;
				sac_pkg::ADDR_FLAG:   next_rdata = {1'b0, doneFlag, 6'h00};
				sac_pkg::ADDR_IRQEN:  next_rdata = {1'b0, doneIrqEn, 6'h00};
				sac_pkg::ADDR_PORT:   next_rdata = {2'h0, portPins & ~analogPins};
				default:              next_rdata = sac_pkg::RST_RDATA;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdata <= sac_pkg::RST_RDATA;
		end else begin
			rdata <= next_rdata;
		end
	end

	sequence s_rc_start;
		startReq && (clkSel == sac_pkg::CLK_SEL_RC);
	endsequence

	sequence s_quiet4;
		(!wrEn)[*4];
	endsequence

	property p_rc_wait;
		@(posedge mclk) disable iff (sys_rst)
		s_rc_start ##1 s_quiet4 |=> (st == sac_pkg::ST_CONV) && ($past(st, 4) == sac_pkg::ST_RCWAIT);
	endproperty
	a_rc_wait: assert property (p_rc_wait) else $error("RC start did not wait one cycle");

	property p_done;
		@(posedge mclk) disable iff (sys_rst)
		doneEv |=> doneFlag && !goFlag && (result == $past(sar)) && (st == sac_pkg::ST_HOLD);
	endproperty
	a_done: assert property (p_done) else $error("completion effects missing");

	property p_conv_len;
		@(posedge mclk) disable iff (sys_rst)
		doneEv |-> halfTick && (halfCnt == 5'h12) && (st == sac_pkg::ST_CONV);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

	property p_abort;
		@(posedge mclk) disable iff (sys_rst)
		abortReq && converterOn && !powerDown |=> (st == sac_pkg::ST_HOLD) && $stable(result)
			&& !doneFlag == !$past(doneFlag);
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not keep result");

	property p_off;
		@(posedge mclk) disable iff (sys_rst)
		!converterOn |-> !powered && !sampleOn ##1 (st == sac_pkg::ST_IDLE);
	endproperty
	a_off: assert property (p_off) else $error("converter active while off");

	property p_hold_open;
		@(posedge mclk) disable iff (sys_rst)
		(st == sac_pkg::ST_HOLD) || goFlag |-> !sampleOn;
	endproperty
	a_hold_open: assert property (p_hold_open) else $error("holding cap connected early");

	property p_hold_end;
		@(posedge mclk) disable iff (sys_rst)
		(st == sac_pkg::ST_HOLD) && converterOn && !powerDown && (next_st == sac_pkg::ST_IDLE)
			|-> halfTick && (halfCnt == 5'h03);
	endproperty
	a_hold_end: assert property (p_hold_end) else $error("hold did not last two periods");

	property p_sleep_abort;
		@(posedge mclk) disable iff (sys_rst)
		cpuSleep && (clkSel != sac_pkg::CLK_SEL_RC) && (st == sac_pkg::ST_CONV) && converterOn
			&& !powerDown && !wrEn |=> (st == sac_pkg::ST_IDLE) && powerDown && converterOn
			&& $stable(result);
	endproperty
	a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");

	property p_wake;
		@(posedge mclk) disable iff (sys_rst)
		doneEv && cpuSleep |=> ($past(doneIrqEn) ? wakeReq : (powerDown && !wakeReq));
	endproperty
	a_wake: assert property (p_wake) else $error("sleep completion handling wrong");

	property p_port_read;
		@(posedge mclk) disable iff (sys_rst)
		rdEn && (addr == sac_pkg::ADDR_PORT) |=> ((rdata[5:0] & $past(analogPins)) == 6'h00);
	endproperty
	a_port_read: assert property (p_port_read) else $error("analog pin read nonzero");

	property p_cfg_read;
		@(posedge mclk) disable iff (sys_rst)
		rdEn && (addr == sac_pkg::ADDR_PINCFG) |=> (rdata == {5'h00, $past(pinCfg)});
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("pin field readback wrong");

	property p_ref;
		@(posedge mclk) disable iff (sys_rst)
		wrPinCfg |=> (refExternal == ($past(wdata[0]) && ($past(wdata[2:0]) != 3'h7)));
	endproperty
	a_ref: assert property (p_ref) else $error("reference select wrong");

endmodule : sac_control

/* File: bench/sac_control_bench.sv */
`timescale 1ns/1ps
module sac_control_bench;
	localparam logic [7:0] CT    = sac_pkg::ADDR_CTRL;
	localparam logic [7:0] PC    = sac_pkg::ADDR_PINCFG;
	localparam logic [7:0] RS    = sac_pkg::ADDR_RESULT;
	localparam logic [7:0] FL    = sac_pkg::ADDR_FLAG;
	localparam logic [7:0] IE    = sac_pkg::ADDR_IRQEN;
	localparam logic [7:0] PT    = sac_pkg::ADDR_PORT;
	localparam int         LIMIT = 20000;
	logic       mclk        = 1'b0;
	logic       sys_rst     = 1'b1;
	logic [7:0] addr        = 8'h00;
	logic [7:0] wdata       = 8'h00;
	logic       wrEn        = 1'b0;
	logic       rdEn        = 1'b0;
	logic       compHigh    = 1'b0;
	logic [5:0] portPins    = 6'h3f;
	logic       cpuSleep    = 1'b0;
	logic [7:0] rdata;
	logic [1:0] chanSel;
	logic       refExternal;
	logic [5:0] analogPins;
	logic       sampleOn;
	logic       powered;
	logic [7:0] dacCode;
	logic       wakeReq;
	logic       pinCfgWrote;
	logic [7:0] vin         = 8'h00;
	logic [7:0] got;
	logic [7:0] lastRes;
	int         miscompares = 0;
	int         totalChecks = 0;
	int         cycles      = 0;

	sac_control i_sac_control (
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.addr        (addr),
		.wdata       (wdata),
		.wrEn        (wrEn),
		.rdEn        (rdEn),
		.compHigh    (compHigh),
		.portPins    (portPins),
		.cpuSleep    (cpuSleep),
		.rdata       (rdata),
		.chanSel     (chanSel),
		.refExternal (refExternal),
		.analogPins  (analogPins),
		.sampleOn    (sampleOn),
		.powered     (powered),
		.dacCode     (dacCode),
		.wakeReq     (wakeReq),
		.pinCfgWrote (pinCfgWrote)
	);

	always #20 mclk = ~mclk;

	// The comparator sees the bench's analog level against the trial code.
	always @(posedge mclk) compHigh <= (vin >= dacCode);

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			miscompares++;
			finalReport();
		end
	end

	task automatic finalReport();
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finalReport

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wrEn  <= 1'b1;
		@(posedge mclk);
		wrEn  <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge mclk);
		rdEn <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	task automatic waitIdle(output int n);
		n = 0;
		while (sampleOn !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask : waitIdle

	task automatic testReset();
		check("dac", dacCode, 8'h80);
		check("mask", {2'b00, analogPins}, 8'h17);
		check("power", {7'h00, powered}, 8'h00);
		rd(CT, got); check("ctrl", got, 8'h00);
		rd(PC, got); check("pincfg", got, 8'h00);
		rd(RS, got); check("result", got, 8'h00);
		rd(FL, got); check("flag", got, 8'h00);
		rd(8'h55, got); check("unmapped", got, 8'h00);
		$display("reset test done");
	endtask : testReset

	task automatic testPins();
		logic [5:0] m [8] = '{6'h17, 6'h17, 6'h07, 6'h07, 6'h03, 6'h03, 6'h01, 6'h00};
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			wr(PC, {5'h1f, c});
			check("cfgpulse", {7'h00, pinCfgWrote}, 8'h01);
			rd(PC, got); check("pincfg", got, {5'h00, c});
			check("mask", {2'b00, analogPins}, {2'b00, m[i]});
			check("ref", {7'h00, refExternal}, {7'h00, c[0] && c != 3'h7});
			rd(PT, got); check("port", got, {2'b00, 6'h3f & ~m[i]});
		end
		wr(PC, 8'h00);
		$display("pin test done");
	endtask : testPins

	task automatic testOff();
		wr(CT, 8'h00);
		wr(CT, 8'h04);
		rd(CT, got); check("go off", got, 8'h00);
		check("power", {7'h00, powered}, 8'h00);
		wr(CT, 8'h01);
		repeat (2) @(posedge mclk);
		#1 check("power", {7'h00, powered}, 8'h01);
		$display("off test done");
	endtask : testOff

	task automatic conv(input logic [1:0] sel, input logic [1:0] ch, input logic [7:0] v,
		input int half);
		logic [7:0] ctl;
		int n;
		logic ok;
		ctl = {sel, 1'b0, ch, 3'b001};
		vin = v;
		wr(CT, ctl);
		repeat (4) @(posedge mclk);
		wr(CT, ctl | 8'h04);
		check("trial", dacCode, 8'h80);
		check("sample", {7'h00, sampleOn}, 8'h00);
		check("chan", {6'h00, chanSel}, {6'h00, ch});
		rd(CT, got); check("busy", got, ctl | 8'h04);
		rd(RS, got); check("held", got, lastRes);
		waitIdle(n);
		ok = (n >= 23 * half - 4) && (n <= 24 * half + 12);
		check("time", {7'h00, ok}, 8'h01);
		rd(RS, got); check("result", got, v);
		rd(CT, got); check("gone", got, ctl);
		rd(FL, got); check("done", got, 8'h40);
		wr(FL, 8'h00);
		rd(FL, got); check("clear", got, 8'h00);
		lastRes = v;
		$display("conversion test done");
	endtask : conv

	task automatic testAbort();
		int n;
		logic ok;
		vin = 8'h3c;
		wr(CT, 8'h49);
		wr(CT, 8'h4d);
		repeat (20) @(posedge mclk);
		rd(CT, got); check("busy", got, 8'h4d);
		wr(CT, 8'h49);
		waitIdle(n);
		ok = (n >= 14) && (n <= 30);
		check("holdoff", {7'h00, ok}, 8'h01);
		rd(RS, got); check("kept", got, lastRes);
		rd(FL, got); check("noflag", got, 8'h00);
		$display("abort test done");
	endtask : testAbort

	task automatic testSleep();
		int n;
		wr(IE, 8'h40);
		vin = 8'h77;
		wr(CT, 8'hc1);
		wr(CT, 8'hc5);
		@(posedge mclk) cpuSleep <= 1'b1;
		n = 0;
		while (wakeReq !== 1'b1 && n < 1400) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check("wake", {7'h00, wakeReq}, 8'h01);
		@(posedge mclk) cpuSleep <= 1'b0;
		waitIdle(n);
		rd(RS, got); check("result", got, 8'h77);
		wr(FL, 8'h00);
		wr(IE, 8'h00);
		vin = 8'h21;
		wr(CT, 8'hc5);
		@(posedge mclk) cpuSleep <= 1'b1;
		repeat (1500) @(posedge mclk);
		#1 check("sleepoff", {7'h00, powered}, 8'h00);
		@(posedge mclk) cpuSleep <= 1'b0;
		repeat (3) @(posedge mclk);
		#1 check("power", {7'h00, powered}, 8'h01);
		rd(RS, got); check("result", got, 8'h21);
		wr(FL, 8'h00);
		wr(CT, 8'h41);
		vin = 8'h99;
		wr(CT, 8'h45);
		repeat (10) @(posedge mclk);
		cpuSleep <= 1'b1;
		repeat (3) @(posedge mclk);
		#1 check("sleepoff", {7'h00, powered}, 8'h00);
		rd(CT, got); check("on kept", got & 8'h05, 8'h01);
		@(posedge mclk) cpuSleep <= 1'b0;
		repeat (40) @(posedge mclk);
		rd(RS, got); check("kept", got, 8'h21);
		rd(FL, got); check("noflag", got, 8'h00);
		$display("sleep test done");
	endtask : testSleep

	initial begin
		lastRes = 8'h00;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		#1;
		testReset();
		testPins();
		testOff();
		conv(sac_pkg::CLK_SEL_DIV2, 2'h0, 8'hff, int'(sac_pkg::DIV2_HALF));
		conv(sac_pkg::CLK_SEL_DIV8, 2'h1, 8'h00, int'(sac_pkg::DIV8_HALF));
		conv(sac_pkg::CLK_SEL_DIV32, 2'h2, 8'h5a, int'(sac_pkg::DIV32_HALF));
		conv(sac_pkg::CLK_SEL_RC, 2'h3, 8'ha5, int'(sac_pkg::RC_HALF));
		testAbort();
		testSleep();
		finalReport();
	end
endmodule : sac_control_bench
